// ===== include/fifo_host_pkg.sv
package fifo_host_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADR_WIN_FIRST = 8'h00;
    localparam logic [7:0] ADR_WIN_LAST  = 8'h31;
    localparam logic [7:0] ADR_STATUS    = 8'h35;
    localparam logic [7:0] ADR_CNT_LO    = 8'h38;
    localparam logic [7:0] ADR_CNT_HI    = 8'h39;
    localparam logic [7:0] ADR_CTRL      = 8'h55;
    localparam int         WIN_BYTES     = 50;
    localparam logic [7:0] PAD_BYTE      = 8'h00;
    // link_control bits
    localparam int CTL_ABORT   = 0;
    localparam int CTL_UPDATE  = 1;
    localparam int CTL_SLEEP   = 2;
    localparam int CTL_WAKEDIS = 3;
    localparam int CTL_OVFMETA = 4;
    localparam logic [7:0] CTL_KEEP_MASK = 8'h1C;
    localparam logic [7:0] CTL_RESET     = 8'h10;
    // irq_cause_flags bits
    localparam int CAU_RESET = 0;
    localparam int CAU_DATA  = 1;
    localparam int CAU_META  = 2;
    localparam int CAU_WAKE  = 3;
    localparam logic [7:0] CAU_RESET_VAL = 8'h01;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_HZ       = 32000;
    localparam int TICK_CYC      = 1000000000 / (TICK_HZ * CLK_PERIOD_NS);
    localparam int IRQ_LOW_NS    = 3000;
    localparam int IRQ_LOW_CYC   = (IRQ_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INS_LAST      = 8;
    localparam int INS_TS_FIRST  = 3;
    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } link_req_s;

    typedef struct packed {
        logic sample;
        logic latency;
        logic watermark;
        logic meta;
        logic wakeup;
        logic wake_wm;
    } irq_cause_s;

    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_MEM  = 3'b010,
        S_ANS  = 3'b100
    } bus_state_e;
endpackage : fifo_host_pkg

// ===== core/window_ram.sv
`timescale 1ns/1ps
// two transfer buffers side by side; read data leave from a register
module window_ram #(
    parameter int DEPTH = 100,
    parameter int AW    = 7
) (
    // clock
    input  wire logic          clk_in,
    // write side
    input  wire logic          we_in,
    input  wire logic [AW-1:0] waddr_in,
    input  wire logic [7:0]    wdata_in,
    // read side
    input  wire logic [AW-1:0] raddr_in,
    output logic      [7:0]    rdata_out
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
        rdata_out <= mem[raddr_in];
    end
endmodule : window_ram

// ===== core/fifo_host_transfer.sv
`timescale 1ns/1ps
// Behaviour
// RQ1: window 0x00..0x31 follows the transfer protocol, not plain registers
// RQ2: host reads fill count, then exactly that many bytes
// RQ3: two 50-byte buffers filled from the core until the count is delivered
// RQ4: reading past 0x31 swaps buffers; emptied one refills
// RQ5: host starts each read with write of address, repeated start, read
// RQ6: host splits long reads into 50-byte multiples from address zero
// RQ7: host reads whole buffers or resumes at the right address
// RQ8: reads beyond the count return zero pad bytes
// RQ9: interrupt high after reset; cleared by patch load or status read
// RQ10: interrupt on zero-latency sample, latency expiry or watermark
// RQ11: interrupt on enabled meta events
// RQ12: while host sleeps only wakeup events or wake watermark interrupt
// RQ13: interrupt holds until FIFO emptied or abort written; here a status read or patch load also drops it
// RQ14: interrupt stays low a few microseconds between transfers
// RQ15: 32-bit 32 kHz timestamp captured at each interrupt rising edge
// RQ16: host resumes at bytes transferred modulo 50
// RQ17: update-count bit refreshes count without changing transfer length
// RQ18: overflow discards oldest data first
// RQ19: after overflow insert meta, time high, time low, then data
// RQ20: host sets sleep bit before sleeping
// RQ21: clearing sleep bit with interrupt pending refreshes the count
// RQ22: short read withholds new interrupts until finished or aborted
// RQ23: zero identifier is a one-byte no-op, so pads end the data
// RQ24: count low byte at lower address; low read freezes high byte
module fifo_host_transfer
    import fifo_host_pkg::*;
#(
    parameter int         WIN      = WIN_BYTES,
    parameter logic [7:0] OVF_CODE = 8'hF0,
    parameter logic [7:0] TSH_CODE = 8'hF1,
    parameter logic [7:0] TSL_CODE = 8'hF2
) (
    // system clock and reset
    input  wire logic                    sys_clk_in,
    input  wire logic                    rst_in,
    // link side byte port from the bus engine, on the link clock
    input  wire logic                    link_clk_in,
    input  wire logic                    link_rst_in,
    input  wire logic                    lnk_req_in,
    input  wire fifo_host_pkg::link_req_s lnk_cmd_in,
    output logic                         lnk_ack_out,
    output logic                         lnk_busy_out,
    output logic [7:0]                   lnk_rdata_out,
    // core data stream and status
    input  wire logic                    core_valid_in,
    input  wire logic [7:0]              core_data_in,
    output logic                         core_ready_out,
    input  wire logic [15:0]             fifo_level_in,
    input  wire logic                    core_overflow_in,
    input  wire logic [15:0]             core_loss_in,
    input  wire fifo_host_pkg::irq_cause_s cause_in,
    input  wire logic                    patch_load_in,
    // host interrupt
    output logic                         host_irq_out,
    output logic [31:0]                  irq_time_out
);
    import fifo_host_pkg::*;

    localparam int AW = $clog2(2 * WIN);

    function automatic logic [AW-1:0] buf_addr(input logic bank, input logic [7:0] idx);
        buf_addr = bank ? AW'(WIN) + AW'(idx) : AW'(idx);
    endfunction : buf_addr

    // ****************************************
    // link domain
    // ****************************************
    // request words stay in req_hold until the ack toggles back
    link_req_s req_hold;
    logic      req_tgl, ack_s1, ack_s2, ack_seen;
    logic      ack_tgl;
    logic [7:0] ans_data;
    link_req_s next_req_hold;
    logic      next_req_tgl, next_busy, next_ack;
    logic [7:0] next_lrdata;

    always_comb begin
        next_req_hold = req_hold;
        next_req_tgl  = req_tgl;
        next_busy     = lnk_busy_out;
        next_ack      = 1'b0;
        next_lrdata   = lnk_rdata_out;
        if (lnk_req_in && !lnk_busy_out) begin
            next_req_hold = lnk_cmd_in;
            next_req_tgl  = ~req_tgl;
            next_busy     = 1'b1;
        end
        if (ack_s2 != ack_seen) begin
            next_busy   = 1'b0;
            next_ack    = 1'b1;
            next_lrdata = ans_data;
        end
    end

    always_ff @(posedge link_clk_in) begin
        if (link_rst_in) begin
            req_hold      <= '0;
            req_tgl       <= 1'b0;
            ack_s1        <= 1'b0;
            ack_s2        <= 1'b0;
            ack_seen      <= 1'b0;
            lnk_busy_out  <= 1'b0;
            lnk_ack_out   <= 1'b0;
            lnk_rdata_out <= '0;
        end else begin
            req_hold      <= next_req_hold;
            req_tgl       <= next_req_tgl;
            ack_s1        <= ack_tgl;
            ack_s2        <= ack_s1;
            ack_seen      <= ack_s2;
            lnk_busy_out  <= next_busy;
            lnk_ack_out   <= next_ack;
            lnk_rdata_out <= next_lrdata;
        end
    end

    // ****************************************
    // system domain state
    // ****************************************
    logic        req_s1, req_s2, req_seen;
    link_req_s   req_q;
    bus_state_e  state;
    logic [7:0]  ctrl, cause_flags, cnt_hi_shadow;
    logic        host_irq, xfer_active, req_pend;
    logic [15:0] cnt, remaining, fill_left;
    logic [1:0]  bank_full;
    logic        fill_bank, rd_bank;
    logic [7:0]  fill_idx;
    logic        ovf_pending, ins_active;
    logic [3:0]  ins_idx;
    logic [15:0] loss;
    logic [31:0] ts, ts_snap;
    logic [10:0] tick_div;
    logic [7:0]  low_cnt;
    logic [7:0]  mem_rdata;

    link_req_s   next_req_q;
    bus_state_e  next_state;
    logic [7:0]  next_ctrl, next_cause, next_shadow, next_ans, next_low;
    logic        next_irq, next_xfer, next_pend, next_ack_tgl;
    logic [15:0] next_cnt, next_rem, next_fill_left, next_loss;
    logic [1:0]  next_full;
    logic        next_fill_bank, next_rd_bank, next_ovf, next_ins, next_ready;
    logic [7:0]  next_fill_idx, wr_data;
    logic [3:0]  next_ins_idx;
    logic [31:0] next_ts, next_snap, next_irq_time;
    logic [10:0] next_div;
    logic        fire, wr_en, rd_win, sleep;
    irq_cause_s  c;

    window_ram #(.DEPTH(2 * WIN), .AW(AW)) u_ram (
        .clk_in   (sys_clk_in),
        .we_in    (wr_en),
        .waddr_in (buf_addr(fill_bank, fill_idx)),
        .wdata_in (wr_data),
        .raddr_in (buf_addr(rd_bank, req_q.addr)),
        .rdata_out(mem_rdata)
    );

    always_comb begin
        next_req_q = req_q;       next_state = state;     next_ctrl = ctrl;
        next_cause = cause_flags; next_shadow = cnt_hi_shadow;
        next_ans = ans_data;      next_irq = host_irq;    next_xfer = xfer_active;
        next_pend = req_pend;     next_ack_tgl = ack_tgl; next_cnt = cnt;
        next_rem = remaining;     next_fill_left = fill_left;
        next_full = bank_full;    next_fill_bank = fill_bank;
        next_rd_bank = rd_bank;   next_fill_idx = fill_idx;
        next_ovf = ovf_pending;   next_ins = ins_active;  next_ins_idx = ins_idx;
        next_loss = loss;         next_snap = ts_snap;    next_irq_time = irq_time_out;
        next_low = (low_cnt != '0) ? low_cnt - 8'h01 : low_cnt;
        wr_en = 1'b0;
        wr_data = PAD_BYTE;
        c = cause_in;
        sleep = ctrl[CTL_SLEEP];
        rd_win = req_q.addr <= ADR_WIN_LAST;
        // shared time base for interrupt edges and inserted time events
        next_div = (tick_div == 11'(TICK_CYC - 1)) ? '0 : tick_div + 11'h001;
        next_ts  = (tick_div == 11'(TICK_CYC - 1)) ? ts + 32'h1 : ts;
        fire = sleep ? ((c.wakeup && !ctrl[CTL_WAKEDIS]) || c.wake_wm)    // [RQ12]
                     : (c.sample || c.latency || c.watermark || c.meta);  // [RQ10] [RQ11]
        if (fire) begin
            next_pend = 1'b1;
        end
        // overflow: core already dropped its oldest bytes; mark the gap
        if (core_overflow_in) begin                                       // [RQ18]
            next_ovf  = 1'b1;
            next_loss = core_loss_in;
            next_snap = ts;
        end

        // ---- fill the buffers, inserted marker bytes first ----
        if (xfer_active && fill_left != '0 && !bank_full[fill_bank]) begin
            if (ins_active) begin                                          // [RQ19]
                wr_en = 1'b1;
                case (ins_idx)
                    4'h0: wr_data = OVF_CODE;
                    4'h1: wr_data = loss[7:0];
                    4'h2: wr_data = loss[15:8];
                    4'h3: wr_data = TSH_CODE;
                    4'h4: wr_data = ts_snap[23:16];
                    4'h5: wr_data = ts_snap[31:24];
                    4'h6: wr_data = TSL_CODE;
                    4'h7: wr_data = ts_snap[7:0];
                    default: wr_data = ts_snap[15:8];
                endcase
                next_ins_idx = ins_idx + 4'h1;
                if (ins_idx == 4'(INS_LAST)) begin
                    next_ins = 1'b0;
                    next_ovf = core_overflow_in;
                end
            end else if (ovf_pending) begin
                next_ins     = 1'b1;
                next_ins_idx = ctrl[CTL_OVFMETA] ? '0 : 4'(INS_TS_FIRST);
            end else if (core_valid_in && core_ready_out) begin            // [RQ3]
                wr_en   = 1'b1;
                wr_data = core_data_in;
            end
        end
        if (wr_en) begin
            next_fill_left = fill_left - 16'h1;
            next_fill_idx  = fill_idx + 8'h01;
            if (fill_idx == 8'(WIN - 1) || fill_left == 16'h1) begin
                next_full[fill_bank] = 1'b1;
                next_fill_bank = ~fill_bank;
                next_fill_idx  = '0;
            end
        end

        // ---- register access from the link ----
        case (state)
            S_IDLE: begin
                if (req_s2 != req_seen) begin
                    next_req_q = req_hold;
                    next_state = S_MEM;
                end
            end
            S_MEM: begin
                next_state = S_ANS;
            end
            S_ANS: begin
                next_state   = S_IDLE;
                next_ack_tgl = ~ack_tgl;
                next_ans     = '0;
                if (req_q.we) begin
                    if (req_q.addr == ADR_CTRL) begin
                        next_ctrl = req_q.wdata & CTL_KEEP_MASK;
                        if (req_q.wdata[CTL_UPDATE]) begin
                            next_cnt = fifo_level_in;                      // [RQ17]
                        end
                        if (sleep && !req_q.wdata[CTL_SLEEP] && host_irq) begin
                            next_cnt = fifo_level_in;                      // [RQ21]
                        end
                        if (req_q.wdata[CTL_ABORT]) begin                  // [RQ13] [RQ22]
                            next_xfer = 1'b0;
                            next_irq  = 1'b0;
                            next_full = '0;
                            next_ins  = 1'b0;
                            next_low  = 8'(IRQ_LOW_CYC);
                        end
                    end
                end else if (rd_win) begin                                 // [RQ1]
                    if (xfer_active && remaining != '0) begin
                        next_ans = mem_rdata;
                        next_rem = remaining - 16'h1;
                        if (remaining == 16'h1) begin                      // [RQ13] [RQ14]
                            next_xfer = 1'b0;
                            next_irq  = 1'b0;
                            next_full = '0;
                            next_low  = 8'(IRQ_LOW_CYC);
                        end
                    end else begin
                        next_ans = PAD_BYTE;                               // [RQ8] [RQ23]
                    end
                    if (req_q.addr == ADR_WIN_LAST) begin                  // [RQ4]
                        next_full[rd_bank] = 1'b0;
                        next_rd_bank = ~rd_bank;
                    end
                end else if (req_q.addr == ADR_STATUS) begin
                    next_ans   = cause_flags;
                    next_cause = '0;
                    next_irq   = 1'b0;                                     // [RQ9]
                end else if (req_q.addr == ADR_CNT_LO) begin
                    next_ans    = cnt[7:0];                                // [RQ24]
                    next_shadow = cnt[15:8];
                end else if (req_q.addr == ADR_CNT_HI) begin
                    next_ans = cnt_hi_shadow;
                end else if (req_q.addr == ADR_CTRL) begin
                    next_ans = ctrl;
                end
            end
            default: next_state = S_IDLE;
        endcase
        if (patch_load_in) begin
            next_irq = 1'b0;                                               // [RQ9]
        end

        // ---- start a transfer: only when none is open ----
        // an abort or an end in this same cycle also holds the start off
        if (!xfer_active && req_pend && low_cnt == '0 && next_low == '0
            && fifo_level_in != '0) begin                                  // [RQ22]
            next_irq       = 1'b1;
            next_xfer      = 1'b1;
            next_pend      = fire;
            next_cnt       = fifo_level_in;
            next_rem       = fifo_level_in;
            next_fill_left = fifo_level_in;
            next_full      = '0;
            next_fill_bank = 1'b0;
            next_rd_bank   = 1'b0;
            next_fill_idx  = '0;
        end
        // hardware sets win over a status read in the same cycle
        if (fire) begin
            next_cause[CAU_DATA] = next_cause[CAU_DATA] | c.sample | c.latency | c.watermark;
            next_cause[CAU_META] = next_cause[CAU_META] | c.meta;
            next_cause[CAU_WAKE] = next_cause[CAU_WAKE] | c.wakeup | c.wake_wm;
        end
        if (next_irq && !host_irq) begin
            next_irq_time = ts;                                            // [RQ15]
        end
        next_ready = next_xfer && !next_ins && !next_ovf && next_fill_left != '0
                     && !next_full[next_fill_bank];                        // [RQ3]
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            req_s1 <= 1'b0; req_s2 <= 1'b0; req_seen <= 1'b0;
            req_q <= '0; state <= S_IDLE; ctrl <= CTL_RESET;
            cause_flags <= CAU_RESET_VAL; cnt_hi_shadow <= '0; ans_data <= '0;
            host_irq <= 1'b1;                                              // [RQ9]
            xfer_active <= 1'b0; req_pend <= 1'b0; ack_tgl <= 1'b0;
            cnt <= '0; remaining <= '0; fill_left <= '0; bank_full <= '0;
            fill_bank <= 1'b0; rd_bank <= 1'b0; fill_idx <= '0;
            ovf_pending <= 1'b0; ins_active <= 1'b0; ins_idx <= '0;
            loss <= '0; ts <= '0; ts_snap <= '0; tick_div <= '0; low_cnt <= '0;
            core_ready_out <= 1'b0; irq_time_out <= '0;
        end else begin
            req_s1 <= req_tgl; req_s2 <= req_s1; req_seen <= req_s2;
            req_q <= next_req_q; state <= next_state; ctrl <= next_ctrl;
            cause_flags <= next_cause; cnt_hi_shadow <= next_shadow; ans_data <= next_ans;
            host_irq <= next_irq; xfer_active <= next_xfer; req_pend <= next_pend;
            ack_tgl <= next_ack_tgl; cnt <= next_cnt; remaining <= next_rem;
            fill_left <= next_fill_left; bank_full <= next_full;
            fill_bank <= next_fill_bank; rd_bank <= next_rd_bank; fill_idx <= next_fill_idx;
            ovf_pending <= next_ovf; ins_active <= next_ins; ins_idx <= next_ins_idx;
            loss <= next_loss; ts <= next_ts; ts_snap <= next_snap; tick_div <= next_div;
            low_cnt <= next_low; core_ready_out <= next_ready; irq_time_out <= next_irq_time;
        end
    end

    assign host_irq_out = host_irq;

    // ****************************************
    // assertions
    // ****************************************
    wire ans_rd = state == S_ANS && !req_q.we;
    wire ans_wr = state == S_ANS && req_q.we && req_q.addr == ADR_CTRL;

    property p_pad;
        @(posedge sys_clk_in) disable iff (rst_in)
        ans_rd && rd_win && remaining == '0 |=> ans_data == PAD_BYTE;
    endproperty
    a_pad: assert property (p_pad) else $error("pad byte not zero"); // [RQ8]

    property p_swap;
        @(posedge sys_clk_in) disable iff (rst_in)
        ans_rd && req_q.addr == ADR_WIN_LAST && xfer_active |=> rd_bank != $past(rd_bank);
    endproperty
    a_swap: assert property (p_swap) else $error("buffers did not swap"); // [RQ4]

    property p_low_time;
        @(posedge sys_clk_in) disable iff (rst_in)
        $fell(xfer_active) |-> !host_irq ##1 !host_irq[*8];
    endproperty
    a_low_time: assert property (p_low_time) else $error("irq low time short"); // [RQ14]

    property p_no_new_irq;
        @(posedge sys_clk_in) disable iff (rst_in)
        $rose(host_irq) |-> !$past(xfer_active) && $past(low_cnt) == '0;
    endproperty
    a_no_new_irq: assert property (p_no_new_irq) else $error("irq raised mid transfer"); // [RQ22]

    property p_status_clear;
        @(posedge sys_clk_in) disable iff (rst_in)
        ans_rd && req_q.addr == ADR_STATUS && xfer_active |=> !host_irq;
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("status read kept irq"); // [RQ9]

    property p_ts_capture;
        @(posedge sys_clk_in) disable iff (rst_in)
        $rose(host_irq) |-> irq_time_out == $past(ts);
    endproperty
    a_ts_capture: assert property (p_ts_capture) else $error("irq time wrong"); // [RQ15]

    property p_update;
        @(posedge sys_clk_in) disable iff (rst_in)
        ans_wr && req_q.wdata[CTL_UPDATE] && xfer_active
        |=> cnt == $past(fifo_level_in) && remaining == $past(remaining);
    endproperty
    a_update: assert property (p_update) else $error("count update wrong"); // [RQ17]

    property p_abort;
        @(posedge sys_clk_in) disable iff (rst_in)
        ans_wr && req_q.wdata[CTL_ABORT] |=> !xfer_active && !host_irq;
    endproperty
    a_abort: assert property (p_abort) else $error("abort ignored"); // [RQ13]

    property p_ready;
        @(posedge sys_clk_in) disable iff (rst_in)
        core_ready_out |-> !bank_full[fill_bank] && fill_left != '0 && xfer_active;
    endproperty
    a_ready: assert property (p_ready) else $error("ready with no room"); // [RQ3]

    property p_pair;
        @(posedge sys_clk_in) disable iff (rst_in)
        ans_rd && req_q.addr == ADR_CNT_LO |=> cnt_hi_shadow == $past(cnt[15:8]);
    endproperty
    a_pair: assert property (p_pair) else $error("count pair broken"); // [RQ24]

    c_irq:  cover property (@(posedge sys_clk_in) disable iff (rst_in) $rose(host_irq));
    c_swap: cover property (@(posedge sys_clk_in) disable iff (rst_in)
                            ans_rd && req_q.addr == ADR_WIN_LAST && xfer_active);
    c_ins:  cover property (@(posedge sys_clk_in) disable iff (rst_in) $rose(ins_active));
endmodule : fifo_host_transfer

// ===== dv/host_model.sv
`timescale 1ns/1ps
module host_model
    import fifo_host_pkg::*;
(
    // link port seen from the host
    input  wire logic                     link_clk_in,
    output logic                          lnk_req_out,
    output fifo_host_pkg::link_req_s      lnk_cmd_out,
    input  wire logic                     lnk_ack_in,
    input  wire logic [7:0]               lnk_rdata_in
);
    initial begin
        lnk_req_out = 1'b0;
        lnk_cmd_out = '1;
    end
    // ****************************************
    // one access; address given each time
    // ****************************************
    task automatic access(input logic we, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] rdata);
        int n;
        n = 0;
        @(negedge link_clk_in);
        lnk_cmd_out = '{we, a, d};
        lnk_req_out = 1'b1;
        @(negedge link_clk_in);
        lnk_req_out = 1'b0;
        while (lnk_ack_in !== 1'b1 && n < 40) begin
            @(negedge link_clk_in);
            n++;
        end
        rdata = lnk_rdata_in;
        // released command shows the inverse, not a stale copy
        lnk_cmd_out = ~lnk_cmd_out;
    endtask : access
endmodule : host_model

// ===== dv/test_fifo_host_transfer.sv
`timescale 1ns/1ps
module test_fifo_host_transfer;
    import fifo_host_pkg::*;
    logic       sys_clk_in = 0, link_clk_in = 0, rst_in = 1, link_rst_in = 1, req, ack, irq;
    logic       core_valid = 0, core_ready;
    logic [7:0] rdata, core_data = 8'h00, rd;
    logic [15:0] level = 16'h0000;
    link_req_s  cmd;
    irq_cause_s cause = '0;
    int         miscompares = 0, tests_run = 0, cycles = 0;
    always #12.5 sys_clk_in = ~sys_clk_in;
    // link clock offset so the two domains never line up
    initial begin
        #3;
        forever #7.5 link_clk_in = ~link_clk_in;
    end
    fifo_host_transfer u_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .link_clk_in(link_clk_in), .link_rst_in(link_rst_in), .lnk_req_in(req),
        .lnk_cmd_in(cmd), .lnk_ack_out(ack), .lnk_busy_out(), .lnk_rdata_out(rdata),
        .core_valid_in(core_valid), .core_data_in(core_data), .core_ready_out(core_ready),
        .fifo_level_in(level), .core_overflow_in(1'b0), .core_loss_in(16'h0000),
        .cause_in(cause), .patch_load_in(1'b0), .host_irq_out(irq), .irq_time_out());
    host_model u_host (.link_clk_in(link_clk_in), .lnk_req_out(req), .lnk_cmd_out(cmd),
        .lnk_ack_in(ack), .lnk_rdata_in(rdata));
    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
        u_host.access(1'b0, a, 8'h00, rd);
        check("register", exp, 16'(rd));
    endtask : reg_rd
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        u_host.access(1'b1, a, d, rd);
    endtask : reg_wr
    task automatic kick(input irq_cause_s v);
        @(negedge sys_clk_in);
        cause = v;
        @(negedge sys_clk_in);
        cause = '0;
    endtask : kick
    // core pushes n bytes; ready seen at the falling edge holds to the next rise
    task automatic transfer(input int n, input logic [7:0] base);
        int i;
        int w;
        i = 0;
        w = 0;
        @(negedge sys_clk_in);
        level = 16'(n);
        kick(6'h20);
        repeat (2) @(negedge sys_clk_in);
        check("irq raised", 16'h1, 16'(irq));
        while (i < n && w < 400) begin
            @(negedge sys_clk_in);
            core_valid = 1'b1;
            core_data = base + 8'(i);
            if (core_ready === 1'b1) i++;
            w++;
        end
        @(negedge sys_clk_in);
        core_valid = 1'b0;
        reg_rd(ADR_CNT_LO, 16'(n & 255));
        reg_rd(ADR_CNT_HI, 16'(n >> 8));
        for (int k = 0; k < n; k++) begin
            reg_rd(8'(k % WIN_BYTES), 16'(base + 8'(k)));
        end
        repeat (4) @(negedge sys_clk_in);
        check("irq after empty", 16'h0, 16'(irq));
        reg_rd(8'(n % WIN_BYTES), 16'(PAD_BYTE));
    endtask : transfer
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            summarize();
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (12) @(negedge sys_clk_in);
        rst_in = 0;
        link_rst_in = 0;
        repeat (4) @(negedge sys_clk_in);
        check("irq at reset", 16'h1, 16'(irq));
        reg_rd(ADR_CTRL, 16'(CTL_RESET));
        reg_rd(8'h40, 16'h0000);
        reg_rd(ADR_STATUS, 16'(CAU_RESET_VAL));
        repeat (4) @(negedge sys_clk_in);
        check("irq cleared", 16'h0, 16'(irq));
        repeat (130) @(negedge sys_clk_in);
        transfer(3, 8'hA0);
        kick(6'h20);
        level = 16'd52;
        repeat (4) @(negedge sys_clk_in);
        check("irq low gap", 16'h0, 16'(irq));
        repeat (130) @(negedge sys_clk_in);
        transfer(52, 8'h10);
        // the cause seen mid transfer restarts one after the low time
        repeat (130) @(negedge sys_clk_in);
        check("irq reassert", 16'h1, 16'(irq));
        level = 16'd7;
        reg_wr(ADR_CTRL, 8'h12);
        reg_rd(ADR_CNT_LO, 16'h0007);
        reg_wr(ADR_CTRL, 8'h11);
        check("irq abort", 16'h0, 16'(irq));
        reg_wr(ADR_CTRL, 8'h14);
        kick(6'h20);
        repeat (130) @(negedge sys_clk_in);
        check("irq asleep", 16'h0, 16'(irq));
        kick(6'h02);
        repeat (2) @(negedge sys_clk_in);
        check("irq wakeup", 16'h1, 16'(irq));
        level = 16'd9;
        reg_wr(ADR_CTRL, 8'h10);
        reg_rd(ADR_CNT_LO, 16'h0009);
        reg_rd(ADR_STATUS, 16'h000A);
        check("irq status clear", 16'h0, 16'(irq));
        summarize();
    end
endmodule : test_fifo_host_transfer
